// ### hdl/dio_pkg.sv
// package for the multifunction digital block: offsets, fields, resets
// assumes a single 200 MHz clock domain and a plain strobed register port
package dio_pkg;

  // ****************************************************************
  // register offsets (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_CMP_LO = 8'h08;
  localparam logic [7:0] OFF_CMP_HI = 8'h0c;
  localparam logic [7:0] OFF_DIR = 8'h10;
  localparam logic [7:0] OFF_OUT_BYTE_LO = 8'h14;
  localparam logic [7:0] OFF_OUT_BYTE_HI = 8'h18;
  localparam logic [7:0] OFF_OUT_WORD = 8'h1c;
  localparam logic [7:0] OFF_IN_BYTE_LO = 8'h20;
  localparam logic [7:0] OFF_IN_BYTE_HI = 8'h24;
  localparam logic [7:0] OFF_IN_WORD = 8'h28;
  localparam logic [7:0] OFF_COUNT = 8'h2c;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [7:0] OFF_SRC = 8'h34;

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int CTRL_POL_BIT = 0;
  localparam int CTRL_TRACK_BIT = 1;
  localparam int CTRL_RRES_BIT = 2;
  localparam int CTRL_FALL_BIT = 3;
  localparam int CTRL_SCAN_LO_BIT = 4;
  localparam int CTRL_SCAN_HI_BIT = 5;
  localparam int CTRL_SCAN_RUN_BIT = 6;
  localparam logic [6:0] CTRL_RESET = 7'h01;

  // ****************************************************************
  // command register fields (write-only pulses)
  // ****************************************************************
  localparam int CMD_CLR_LINE_LSB = 0;
  localparam int CMD_CLR_ALL_BIT = 4;
  localparam int CMD_SCAN_START_BIT = 5;
  localparam int CMD_CNT_CLR_BIT = 6;

  // ****************************************************************
  // comparator fields: pattern, mask, mismatch mode, enable
  // ****************************************************************
  localparam int CMP_PAT_LSB = 0;
  localparam int CMP_MASK_LSB = 8;
  localparam int CMP_MISMATCH_BIT = 16;
  localparam int CMP_EN_BIT = 17;
  localparam logic [17:0] CMP_RESET = 18'h10000;

  // ****************************************************************
  // status and source-assignment fields
  // ****************************************************************
  localparam int STAT_REJECT_BIT = 4;
  localparam int STAT_REC_LSB = 8;
  localparam int SRC_LO_LSB = 0;
  localparam int SRC_HI_LSB = 2;
  localparam int SRC_CNT_LSB = 4;

  localparam int PORT_W = 8;
  localparam int COUNT_W = 26;
  localparam int LINES = 4;
  localparam int CTRL_W = 7;
  localparam int CMP_W = 18;
  localparam int DIR_W = 2;
  localparam int SRC_W = 6;
  localparam logic [3:0] LINES_ALL = 4'hf;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 26'h3ffffff;

  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_RUN = 2'b01
  } scan_state_t;

endpackage : dio_pkg

// ### hdl/dio_compare_totalizer_alarm_out.sv
// digital ports, masked comparators, 26-bit edge counter, alarm lines
// assumes pins are asynchronous; register port is on REF_CLK
//
// Contract
// - four alarm lines share polarity; active-low by default
// - polarity change re-drives lines immediately
// - clear command deasserts selected or all lines, records kept
// - scan start deasserts all lines in latched mode and discards alarm records
// - masked port byte compared with pattern; equal or mismatch alarms
// - comparators reset into mismatch mode
// - 8-bit compare pattern per port, read back as stored
// - mask bit 1 compares that bit, 0 ignores it
// - per-port enable; evaluates continuously regardless of scan list
// - alarms always signalled; recorded only while scan runs
// - low and high ports sampled same cycle as one word
// - counter read-only by default or read-and-clear mode
// - counter counts rising edges by default, falling selectable
// - clear command zeroes the count immediately
// - read-and-clear applies to direct reads regardless of scan
// - 26-bit counter wraps to zero after maximum
// - output direction rejected while port in scan list
// - word write drives low byte and high byte together
// - output readback returns last written value, not pins
// - direction query: 0 input, 1 output
// - counter is channel three; ports are channels one and two
// - each line is OR of its assigned port comparators; counter source field has no effect
// - latched mode default holds line; tracking follows condition
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module dio_compare_totalizer_alarm_out
  import dio_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic [7:0] PORT_LO_IN,
  input wire logic [7:0] PORT_HI_IN,
  output logic [7:0] PORT_LO_OUT,
  output logic [7:0] PORT_HI_OUT,
  output logic PORT_LO_OE,
  output logic PORT_HI_OE,
  input wire logic COUNT_IN,
  output logic [3:0] ALARM_OUT
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic cmp_hit(input logic [17:0] cfg, input logic [7:0] din);
    logic match;
    match = ((din & cfg[CMP_MASK_LSB +: PORT_W]) ==
             (cfg[CMP_PAT_LSB +: PORT_W] & cfg[CMP_MASK_LSB +: PORT_W]));
    cmp_hit = cfg[CMP_EN_BIT] & (cfg[CMP_MISMATCH_BIT] ? ~match : match);
  endfunction : cmp_hit

  function automatic logic [3:0] line_sel(input logic [1:0] num);
    line_sel = 4'h1 << num;
  endfunction : line_sel

  function automatic logic reg_hit(input logic strobe, input logic [7:0] a, input logic [7:0] off);
    reg_hit = strobe && (a == off);
  endfunction : reg_hit

  logic wr_ctrl, wr_cmd, wr_cmp_lo, wr_cmp_hi, wr_dir, wr_ob_lo, wr_ob_hi, wr_ow, wr_src;
  logic rd_count;
  assign wr_ctrl = reg_hit(WR, ADDR, OFF_CTRL);
  assign wr_cmd = reg_hit(WR, ADDR, OFF_CMD);
  assign wr_cmp_lo = reg_hit(WR, ADDR, OFF_CMP_LO);
  assign wr_cmp_hi = reg_hit(WR, ADDR, OFF_CMP_HI);
  assign wr_dir = reg_hit(WR, ADDR, OFF_DIR);
  assign wr_ob_lo = reg_hit(WR, ADDR, OFF_OUT_BYTE_LO);
  assign wr_ob_hi = reg_hit(WR, ADDR, OFF_OUT_BYTE_HI);
  assign wr_ow = reg_hit(WR, ADDR, OFF_OUT_WORD);
  assign wr_src = reg_hit(WR, ADDR, OFF_SRC);
  assign rd_count = reg_hit(RD, ADDR, OFF_COUNT);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [7:0] lo_meta_reg, lo_sync_reg, hi_meta_reg, hi_sync_reg;
  logic cnt_meta_reg, cnt_sync_reg, cnt_prev_reg;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      lo_meta_reg <= 8'h00;
      lo_sync_reg <= 8'h00;
    end else begin
      lo_meta_reg <= PORT_LO_IN;
      lo_sync_reg <= lo_meta_reg;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      hi_meta_reg <= 8'h00;
      hi_sync_reg <= 8'h00;
    end else begin
      hi_meta_reg <= PORT_HI_IN;
      hi_sync_reg <= hi_meta_reg;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cnt_meta_reg <= 1'b0;
      cnt_sync_reg <= 1'b0;
      cnt_prev_reg <= 1'b0;
    end else begin
      cnt_meta_reg <= COUNT_IN;
      cnt_sync_reg <= cnt_meta_reg;
      cnt_prev_reg <= cnt_sync_reg;
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  logic [6:0] ctrl_reg;
  logic reject_reg;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= WDATA[CTRL_W-1:0];
    end
  end

  // ****************************************************************
  // comparator configuration
  // ****************************************************************
  logic [17:0] cmp_lo_reg, cmp_hi_reg;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cmp_lo_reg <= CMP_RESET;
      cmp_hi_reg <= CMP_RESET;
    end else begin
      if (wr_cmp_lo) begin
        cmp_lo_reg <= WDATA[CMP_W-1:0];
      end
      if (wr_cmp_hi) begin
        cmp_hi_reg <= WDATA[CMP_W-1:0];
      end
    end
  end

  // ****************************************************************
  // direction and output data
  // ****************************************************************
  logic [1:0] dir_reg;
  logic [7:0] out_lo_reg, out_hi_reg;
  logic [1:0] dir_req;
  logic [1:0] in_scan;
  assign dir_req = WDATA[DIR_W-1:0];
  assign in_scan = {ctrl_reg[CTRL_SCAN_HI_BIT], ctrl_reg[CTRL_SCAN_LO_BIT]};
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      dir_reg <= 2'h0;
    end else if (wr_dir) begin
      dir_reg <= dir_req & ~in_scan;
    end
  end

  // refusal flag, held until next direction write
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      reject_reg <= 1'b0;
    end else if (wr_dir) begin
      reject_reg <= |(dir_req & in_scan);
    end
  end

  // word write drives both bytes at once
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      out_lo_reg <= 8'h00;
      out_hi_reg <= 8'h00;
    end else if (wr_ow) begin
      out_lo_reg <= WDATA[7:0];
      out_hi_reg <= WDATA[PORT_W +: PORT_W];
    end else begin
      if (wr_ob_lo) begin
        out_lo_reg <= WDATA[7:0];
      end
      if (wr_ob_hi) begin
        out_hi_reg <= WDATA[7:0];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      PORT_LO_OUT <= 8'h00;
      PORT_HI_OUT <= 8'h00;
      PORT_LO_OE <= 1'b0;
      PORT_HI_OE <= 1'b0;
    end else begin
      PORT_LO_OUT <= out_lo_reg;
      PORT_HI_OUT <= out_hi_reg;
      PORT_LO_OE <= dir_reg[0];
      PORT_HI_OE <= dir_reg[1];
    end
  end

  // ****************************************************************
  // totalizer
  // ****************************************************************
  logic [COUNT_W-1:0] count_reg;
  logic count_edge;
  assign count_edge = ctrl_reg[CTRL_FALL_BIT] ? (cnt_prev_reg & ~cnt_sync_reg)
                                              : (~cnt_prev_reg & cnt_sync_reg);
  // clear beats read-clear and edge
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      count_reg <= '0;
    end else if (wr_cmd && WDATA[CMD_CNT_CLR_BIT]) begin
      count_reg <= '0;
    end else if (rd_count && ctrl_reg[CTRL_RRES_BIT]) begin
      // clear after read, scan state ignored
      count_reg <= '0;
    end else if (count_edge) begin
      count_reg <= (count_reg == COUNT_MAX) ? '0 : count_reg + 1'b1;
    end
  end

  // ****************************************************************
  // comparators and alarm sources
  // ****************************************************************
  logic hit_lo, hit_hi;
  logic [5:0] src_reg;
  logic [3:0] cond;
  assign hit_lo = cmp_hit(cmp_lo_reg, lo_sync_reg);
  assign hit_hi = cmp_hit(cmp_hi_reg, hi_sync_reg);
  // line is OR of its assigned port comparator hits; counter field ignored
  assign cond = (hit_lo ? line_sel(src_reg[SRC_LO_LSB +: 2]) : 4'h0) |
                (hit_hi ? line_sel(src_reg[SRC_HI_LSB +: 2]) : 4'h0);

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      src_reg <= 6'h00;
    end else if (wr_src) begin
      src_reg <= WDATA[SRC_W-1:0];
    end
  end

  // ****************************************************************
  // scan state and alarm records
  // ****************************************************************
  scan_state_t scan_reg, scan_next;
  logic scan_start;
  logic [1:0] rec_reg;
  assign scan_start = wr_cmd && WDATA[CMD_SCAN_START_BIT];
  always_comb begin
    case (scan_reg)
      SCAN_IDLE: begin
        if (scan_start) begin
          scan_next = SCAN_RUN;
        end else begin
          scan_next = SCAN_IDLE;
        end
      end
      // scan stops only on a ctrl write
      SCAN_RUN: begin
        if (wr_ctrl && !WDATA[CTRL_SCAN_RUN_BIT]) begin
          scan_next = SCAN_IDLE;
        end else begin
          scan_next = SCAN_RUN;
        end
      end
      default: scan_next = SCAN_IDLE;
    endcase
  end
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      scan_reg <= SCAN_IDLE;
    end else begin
      scan_reg <= scan_next;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rec_reg <= 2'h0;
    end else if (scan_start) begin
      rec_reg <= 2'h0;
    end else if (scan_reg == SCAN_RUN) begin
      rec_reg <= rec_reg | {hit_hi, hit_lo};
    end
  end

  // ****************************************************************
  // alarm lines
  // ****************************************************************
  logic [3:0] line_reg;
  logic [3:0] clr_mask;
  always_comb begin
    clr_mask = 4'h0;
    if (wr_cmd && WDATA[CMD_CLR_ALL_BIT]) begin
      clr_mask = LINES_ALL;
    end else if (wr_cmd) begin
      clr_mask = WDATA[CMD_CLR_LINE_LSB +: LINES];
    end
  end
  // set wins over clear in one cycle
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      line_reg <= 4'h0;
    end else if (ctrl_reg[CTRL_TRACK_BIT]) begin
      line_reg <= cond;
    end else if (scan_start) begin
      line_reg <= 4'h0;
    end else begin
      // latched, clear honoured, new events win
      line_reg <= (line_reg & ~clr_mask) | cond;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ALARM_OUT <= LINES_ALL;
    end else begin
      ALARM_OUT <= ctrl_reg[CTRL_POL_BIT] ? ~line_reg : line_reg;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // zero outside the answer cycle
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      RDATA <= 32'h0;
    end else if (RD) begin
      case (ADDR)
        OFF_CTRL: RDATA <= {25'h0, ctrl_reg};
        OFF_CMP_LO: RDATA <= {14'h0, cmp_lo_reg};
        OFF_CMP_HI: RDATA <= {14'h0, cmp_hi_reg};
        OFF_DIR: RDATA <= {30'h0, dir_reg};
        OFF_OUT_BYTE_LO: RDATA <= {24'h0, out_lo_reg};
        OFF_OUT_BYTE_HI: RDATA <= {24'h0, out_hi_reg};
        OFF_OUT_WORD: RDATA <= {16'h0, out_hi_reg, out_lo_reg};
        OFF_IN_BYTE_LO: RDATA <= {24'h0, lo_sync_reg};
        OFF_IN_BYTE_HI: RDATA <= {24'h0, hi_sync_reg};
        OFF_IN_WORD: RDATA <= {16'h0, hi_sync_reg, lo_sync_reg};
        OFF_COUNT: RDATA <= {6'h0, count_reg};
        OFF_STATUS: RDATA <= {22'h0, rec_reg, 3'h0, reject_reg, line_reg};
        OFF_SRC: RDATA <= {26'h0, src_reg};
        default: RDATA <= 32'h0;
      endcase
    end else begin
      RDATA <= 32'h0;
    end
  end

endmodule : dio_compare_totalizer_alarm_out

`default_nettype wire

// ### sim/dio_compare_totalizer_alarm_out_checker.sv
// checker for the digital block: bus answers, port drive, alarm lines
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module dio_compare_totalizer_alarm_out_checker (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic [7:0] PORT_LO_IN,
  input wire logic [7:0] PORT_HI_IN,
  input wire logic [7:0] PORT_LO_OUT,
  input wire logic [7:0] PORT_HI_OUT,
  input wire logic PORT_LO_OE,
  input wire logic PORT_HI_OE,
  input wire logic COUNT_IN,
  input wire logic [3:0] ALARM_OUT
);
  import dio_pkg::*;
  // ****************************************************************
  // control mirror and properties
  // ****************************************************************
  logic pol_q;
  logic rrc_q;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pol_q <= 1'b1;
      rrc_q <= 1'b0;
    end else if (WR && ADDR == OFF_CTRL) begin
      pol_q <= WDATA[CTRL_POL_BIT];
      rrc_q <= WDATA[CTRL_RRES_BIT];
    end
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data not idle");
  chk_unmapped_zero: assert property (RD && ADDR == 8'hfc |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
  chk_reset_idle: assert property ($fell(RST) |-> ALARM_OUT == 4'hf && !PORT_LO_OE && !PORT_HI_OE)
    else $error("outputs not idle after reset");
  chk_word_out: assert property (WR && ADDR == OFF_OUT_WORD ##2 PORT_LO_OE && PORT_HI_OE
    |-> PORT_LO_OUT == $past(WDATA[7:0], 2) && PORT_HI_OUT == $past(WDATA[15:8], 2))
    else $error("word write not driven on both ports");
  chk_dir_read: assert property (RD && ADDR == OFF_DIR |=> RDATA[1:0] == {PORT_HI_OE, PORT_LO_OE})
    else $error("direction readback differs from enables");
  chk_count_clear: assert property (WR && ADDR == OFF_CMD && WDATA[CMD_CNT_CLR_BIT]
    ##2 RD && ADDR == OFF_COUNT |=> RDATA < 32'h3)
    else $error("count not cleared");
  chk_read_clear: assert property (RD && ADDR == OFF_COUNT && rrc_q
    ##2 RD && ADDR == OFF_COUNT |=> RDATA < 32'h3)
    else $error("read did not clear count");
  chk_pol_line: assert property (RD && ADDR == OFF_STATUS
    |=> ALARM_OUT == ($past(pol_q) ? ~RDATA[3:0] : RDATA[3:0]))
    else $error("alarm level disagrees with polarity");
endmodule : dio_compare_totalizer_alarm_out_checker

bind dio_compare_totalizer_alarm_out dio_compare_totalizer_alarm_out_checker u_chk (
  .REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .PORT_LO_IN(PORT_LO_IN), .PORT_HI_IN(PORT_HI_IN),
  .PORT_LO_OUT(PORT_LO_OUT), .PORT_HI_OUT(PORT_HI_OUT), .PORT_LO_OE(PORT_LO_OE),
  .PORT_HI_OE(PORT_HI_OE), .COUNT_IN(COUNT_IN), .ALARM_OUT(ALARM_OUT)
);
`default_nettype wire

// ### sim/dio_pins_model.sv
// far side: digital input levels and a pulse source
// assumes tasks are called from one bench process with the clock running
`timescale 1ns/1ps
`default_nettype none
module dio_pins_model (
  input wire logic clk,
  output logic [7:0] lo,
  output logic [7:0] hi,
  output logic pulse
);
  // ****************************************************************
  // pin drivers
  // ****************************************************************
  initial begin
    lo = 8'h0;
    hi = 8'h0;
    pulse = 1'b0;
  end
  task automatic set_bytes(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    lo <= a;
    hi <= b;
  endtask : set_bytes
  // four cycles a level so the synchroniser never misses it
  task automatic level(input logic v);
    @(posedge clk);
    pulse <= v;
    repeat (3) @(posedge clk);
  endtask : level
  task automatic pulses(input int n);
    repeat (n) begin
      level(1'b1);
      level(1'b0);
    end
  endtask : pulses
endmodule : dio_pins_model
`default_nettype wire

// ### sim/dio_compare_totalizer_alarm_out_bench.sv
// self-checking bench for the digital block
// assumes the pin model and the bound checker sit beside it
`timescale 1ns/1ps
`default_nettype none
module dio_compare_totalizer_alarm_out_bench;
  import dio_pkg::*;
  logic ref_clk;
  logic rst, wr, rd, cnt_in, lo_oe, hi_oe, mode, hit;
  logic [7:0] addr, lo_in, hi_in, lo_out, hi_out, m, p, pin;
  logic [31:0] wdata, rdata, d;
  logic [3:0] alarm;
  logic [15:0] w;
  logic [31:0] cmds [3] = '{32'h2, 32'h10, 32'h20};
  int n_errors = 0;
  int total_checks = 0;
  int cnt_model;
  integer seed = 32'hd1da;
  dio_compare_totalizer_alarm_out DUT (
    .REF_CLK(ref_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PORT_LO_IN(lo_in), .PORT_HI_IN(hi_in), .PORT_LO_OUT(lo_out),
    .PORT_HI_OUT(hi_out), .PORT_LO_OE(lo_oe), .PORT_HI_OE(hi_oe), .COUNT_IN(cnt_in),
    .ALARM_OUT(alarm)
  );
  dio_pins_model PINS (.clk(ref_clk), .lo(lo_in), .hi(hi_in), .pulse(cnt_in));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ****************************************************************
  // bus, compare and closing tasks
  // ****************************************************************
  task automatic check_rd(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_rd
  task automatic check_pin(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_pin
  task automatic wait_cy(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cy
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : bus_rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus_rd(a, d);
    check_rd(d, e);
  endtask : rd_chk
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (6000) @(posedge ref_clk);
    n_errors++;
    report_and_stop();
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(OFF_CTRL, {25'h0, CTRL_RESET});
    rd_chk(OFF_CMP_LO, {14'h0, CMP_RESET});
    rd_chk(OFF_DIR, 32'h0);
    rd_chk(8'hfc, 32'h0);
    bus_wr(OFF_SRC, 32'h9);
    bus_wr(OFF_CTRL, 32'h3);
    for (int i = 0; i < 6; i++) begin
      m = 8'($random(seed));
      p = 8'($random(seed)) & m;
      pin = i[0] ? 8'($random(seed)) : (p | (8'($random(seed)) & ~m));
      mode = i[1];
      hit = ((pin & m) == p) ^ mode;
      bus_wr(OFF_CMP_LO, {14'h0, 1'b1, mode, m, p});
      rd_chk(OFF_CMP_LO, {14'h0, 1'b1, mode, m, p});
      PINS.set_bytes(pin, 8'h0);
      wait_cy(6);
      check_pin({12'h0, alarm}, {12'h0, 4'hf ^ {2'b0, hit, 1'b0}});
    end
    bus_wr(OFF_CMP_LO, 32'h20000);
    wait_cy(6);
    check_pin({12'h0, alarm}, 16'hd);
    bus_wr(OFF_CTRL, 32'h2);
    wait_cy(3);
    check_pin({12'h0, alarm}, 16'h2);
    bus_rd(OFF_STATUS, d);
    bus_wr(OFF_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      bus_wr(OFF_CMP_LO, 32'h20000);
      wait_cy(6);
      bus_wr(OFF_CMP_LO, 32'h0);
      wait_cy(6);
      check_pin({12'h0, alarm}, 16'hd);
      bus_wr(OFF_CMD, cmds[i]);
      wait_cy(4);
      check_pin({12'h0, alarm}, 16'hf);
    end
    // scan is running now: record kept, line cleared
    bus_wr(OFF_CMP_LO, 32'h20000);
    wait_cy(6);
    rd_chk(OFF_STATUS, 32'h102);
    bus_wr(OFF_CMP_LO, 32'h0);
    bus_wr(OFF_CMD, 32'h10);
    wait_cy(2);
    rd_chk(OFF_STATUS, 32'h100);
    bus_wr(OFF_CTRL, 32'h1);
    bus_wr(OFF_CMD, 32'h40);
    cnt_model = 0;
    PINS.pulses(5);
    cnt_model += 5;
    wait_cy(4);
    rd_chk(OFF_COUNT, 32'(cnt_model));
    rd_chk(OFF_COUNT, 32'(cnt_model));
    bus_wr(OFF_CTRL, 32'h5);
    rd_chk(OFF_COUNT, 32'(cnt_model));
    cnt_model = 0;
    rd_chk(OFF_COUNT, 32'(cnt_model));
    bus_wr(OFF_CTRL, 32'h9);
    PINS.level(1'b1);
    wait_cy(4);
    rd_chk(OFF_COUNT, 32'(cnt_model));
    PINS.level(1'b0);
    cnt_model++;
    wait_cy(4);
    rd_chk(OFF_COUNT, 32'(cnt_model));
    bus_wr(OFF_CMD, 32'h40);
    cnt_model = 0;
    rd_chk(OFF_COUNT, 32'(cnt_model));
    bus_wr(OFF_DIR, 32'h3);
    rd_chk(OFF_DIR, 32'h3);
    w = 16'($random(seed));
    bus_wr(OFF_OUT_WORD, {16'h0, w});
    wait_cy(3);
    check_pin({hi_out, lo_out}, w);
    rd_chk(OFF_OUT_WORD, {16'h0, w});
    bus_wr(OFF_DIR, 32'h0);
    bus_wr(OFF_CTRL, 32'h11);
    bus_wr(OFF_DIR, 32'h3);
    rd_chk(OFF_DIR, 32'h2);
    bus_rd(OFF_STATUS, d);
    check_rd(d & 32'h10, 32'h10);
    bus_wr(OFF_CTRL, 32'h1);
    bus_wr(OFF_DIR, 32'h0);
    m = 8'($random(seed));
    p = 8'($random(seed));
    PINS.set_bytes(m, p);
    wait_cy(4);
    rd_chk(OFF_IN_WORD, {16'h0, p, m});
    report_and_stop();
  end
endmodule : dio_compare_totalizer_alarm_out_bench
`default_nettype wire
